/* File: hdl/epsr_pkg.sv */
// package of constants and types for the exception pending-state register block
package epsr_pkg;

   // ***************************************************************
   // bus and register map
   // ***************************************************************
   localparam int EPSR_ADDR_W = 8;
   localparam int EPSR_DATA_W = 32;
   localparam logic [7:0] EPSR_ICS_OFFSET = 8'h04;
   localparam logic [31:0] EPSR_ICS_RESET = 32'h0000_0000;
   localparam logic [1:0] EPSR_RESP_OKAY = 2'h0;
   localparam logic [1:0] EPSR_RESP_SLVERR = 2'h2;
   localparam int EPSR_STRB_CTRL = 3;

   // ***************************************************************
   // field positions of interrupt_control_state
   // ***************************************************************
   localparam int EPSR_SVC_SET_BIT = 28;
   localparam int EPSR_SVC_CLR_BIT = 27;
   localparam int EPSR_TICK_SET_BIT = 26;
   localparam int EPSR_TICK_CLR_BIT = 25;
   localparam int EPSR_ANY_PEND_BIT = 22;
   localparam int EPSR_PEND_NUM_LSB = 12;
   localparam int EPSR_ACT_NUM_LSB = 0;
   localparam int EPSR_NUM_W = 6;

   // ***************************************************************
   // pendable exceptions handled here
   // ***************************************************************
   localparam int EPSR_EXC_SVC = 0;
   localparam int EPSR_EXC_TICK = 1;
   localparam int EPSR_EXC_CNT = 2;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [0:0] {
      EPSR_WR_COLLECT = 1'b0,
      EPSR_WR_RESP = 1'b1
   } epsr_wr_state_t;

   typedef enum logic [0:0] {
      EPSR_RD_IDLE = 1'b0,
      EPSR_RD_DATA = 1'b1
   } epsr_rd_state_t;

   // status and events from the processor core and prioritiser
   typedef struct packed {
      logic [EPSR_NUM_W-1:0] highest_pending_number;
      logic external_irq_pending;
      logic [EPSR_NUM_W-1:0] interrupt_program_status;
      logic tick_event;
      logic service_call_taken;
      logic tick_taken;
   } epsr_core_in_t;

   // pending levels toward the exception prioritiser
   typedef struct packed {
      logic service_call_pending;
      logic tick_pending;
   } epsr_pend_out_t;

   typedef struct packed {
      logic pending;
   } epsr_cell_state_t;

   typedef struct packed {
      epsr_wr_state_t wr_state;
      logic aw_got;
      logic w_got;
      logic [EPSR_ADDR_W-1:0] awaddr;
      logic [EPSR_DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] bresp;
      epsr_rd_state_t rd_state;
      logic [EPSR_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } epsr_state_t;

endpackage : epsr_pkg

/* File: hdl/epsr_pend_cell.sv */
// one pending flag with software set/clear and hardware set/clear
`timescale 1ns/100ps
module epsr_pend_cell
   import epsr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // software requests from a committed register write
   input wire logic sw_set,
   input wire logic sw_clr,
   // hardware requests
   input wire logic hw_set,
   input wire logic hw_clr,
   // state
   output logic pending
);

   epsr_cell_state_t state;
   epsr_cell_state_t next_state;

   // software clear beats software set; a hardware set beats every clear
   always_comb begin
      next_state = state;
      if (sw_set) begin
         next_state.pending = 1'b1;
      end
      if (sw_clr) begin
         next_state.pending = 1'b0;
      end
      if (hw_clr) begin
         next_state.pending = 1'b0;
      end
      if (hw_set) begin
         next_state.pending = 1'b1; // an event must not be lost to a clear
      end
   end

   // register the flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign pending = state.pending;

endmodule : epsr_pend_cell

/* File: hdl/epsr_ctrl.sv */
// pending-state and exception number register behind an AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps

// ***************************************************************
// block top
// ***************************************************************
module epsr_ctrl
   import epsr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address channel
   input wire logic [EPSR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data channel
   input wire logic [EPSR_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address channel
   input wire logic [EPSR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data channel
   output logic [EPSR_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // core status and exception events
   input wire epsr_core_in_t core_in,
   // pending levels toward the prioritiser
   output epsr_pend_out_t pend_out
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   epsr_state_t state;
   epsr_state_t next_state;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic commit;
   logic wr_hit;
   logic ctrl_lane;
   logic [EPSR_EXC_CNT-1:0] sw_set;
   logic [EPSR_EXC_CNT-1:0] sw_clr;
   logic [EPSR_EXC_CNT-1:0] hw_set;
   logic [EPSR_EXC_CNT-1:0] hw_clr;
   logic [EPSR_EXC_CNT-1:0] pending;
   logic any_pending;
   logic [EPSR_NUM_W-1:0] pend_number;
   logic [EPSR_NUM_W-1:0] active_number;
   logic [EPSR_DATA_W-1:0] ics_read;

   // ***************************************************************
   // handshakes
   // ***************************************************************
   // address and data are each taken once per write, in either order
   assign s_axi_awready = (state.wr_state == EPSR_WR_COLLECT) && !state.aw_got;
   assign s_axi_wready = (state.wr_state == EPSR_WR_COLLECT) && !state.w_got;
   assign s_axi_bvalid = (state.wr_state == EPSR_WR_RESP);
   assign s_axi_bresp = state.bresp;
   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;

   // one read at a time; the address is taken only while no data waits
   assign s_axi_arready = (state.rd_state == EPSR_RD_IDLE);
   assign s_axi_rvalid = (state.rd_state == EPSR_RD_DATA);
   assign s_axi_rdata = state.rdata;
   assign s_axi_rresp = state.rresp;
   assign ar_hs = s_axi_arvalid && s_axi_arready;

   // ***************************************************************
   // write decode
   // ***************************************************************
   // a write takes effect one cycle after both halves are held, so the
   // pending flags and bvalid change on the same edge
   assign commit = (state.wr_state == EPSR_WR_COLLECT) && state.aw_got && state.w_got;
   assign wr_hit = (state.awaddr[EPSR_ADDR_W-1:2] == EPSR_ICS_OFFSET[EPSR_ADDR_W-1:2]);

   // the control bits all sit in the top byte lane; without its strobe the
   // write leaves them alone
   assign ctrl_lane = commit && wr_hit && state.wstrb[EPSR_STRB_CTRL];

   // software requests per exception; zeros in any bit have no effect
   always_comb begin
      sw_set = '0;
      sw_clr = '0;
      if (ctrl_lane) begin
         sw_set[EPSR_EXC_SVC] = state.wdata[EPSR_SVC_SET_BIT];
         sw_clr[EPSR_EXC_SVC] = state.wdata[EPSR_SVC_CLR_BIT];
         sw_set[EPSR_EXC_TICK] = state.wdata[EPSR_TICK_SET_BIT];
         sw_clr[EPSR_EXC_TICK] = state.wdata[EPSR_TICK_CLR_BIT];
      end
   end

   // hardware requests: only the tick has a hardware source of pending state;
   // the service call has none, so software alone can make it pend
   always_comb begin
      hw_set = '0;
      hw_clr = '0;
      hw_set[EPSR_EXC_SVC] = 1'b0;
      hw_set[EPSR_EXC_TICK] = core_in.tick_event;
      hw_clr[EPSR_EXC_SVC] = core_in.service_call_taken;
      hw_clr[EPSR_EXC_TICK] = core_in.tick_taken;
   end

   // ***************************************************************
   // pending flags
   // ***************************************************************
   // one flag cell per pendable exception
   generate
      for (genvar i = 0; i < EPSR_EXC_CNT; i++) begin : g_cell
         epsr_pend_cell u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .sw_set(sw_set[i]),
            .sw_clr(sw_clr[i]),
            .hw_set(hw_set[i]),
            .hw_clr(hw_clr[i]),
            .pending(pending[i])
         );
      end
   endgenerate

   // levels toward the prioritiser come straight from the flag flip-flops
   assign pend_out.service_call_pending = pending[EPSR_EXC_SVC];
   assign pend_out.tick_pending = pending[EPSR_EXC_TICK];

   // ***************************************************************
   // status view
   // ***************************************************************
   // the two system exceptions count as pending interrupts as well; NMI
   // and faults never reach this block, so they are never counted
   assign any_pending = core_in.external_irq_pending || (|pending);

   // the prioritiser's number is forced to zero when nothing is pending,
   // so a stale number can never be read
   assign pend_number = any_pending ? core_in.highest_pending_number : '0;

   // mirror of the program status register, no copy of our own to drift
   assign active_number = core_in.interrupt_program_status;

   // read image; everything not named reads zero
   always_comb begin
      ics_read = EPSR_ICS_RESET;
      ics_read[EPSR_SVC_SET_BIT] = pending[EPSR_EXC_SVC];
      ics_read[EPSR_SVC_CLR_BIT] = 1'b0;
      ics_read[EPSR_TICK_SET_BIT] = pending[EPSR_EXC_TICK];
      ics_read[EPSR_TICK_CLR_BIT] = 1'b0;
      ics_read[EPSR_ANY_PEND_BIT] = any_pending;
      ics_read[EPSR_PEND_NUM_LSB +: EPSR_NUM_W] = pend_number;
      ics_read[EPSR_ACT_NUM_LSB +: EPSR_NUM_W] = active_number;
   end

   // ***************************************************************
   // bus state
   // ***************************************************************
   // write and read paths run independently; each holds at most one access
   always_comb begin
      next_state = state;

      // write address capture
      if (aw_hs) begin
         next_state.aw_got = 1'b1;
         next_state.awaddr = s_axi_awaddr;
      end

      // write data capture
      if (w_hs) begin
         next_state.w_got = 1'b1;
         next_state.wdata = s_axi_wdata;
         next_state.wstrb = s_axi_wstrb;
      end

      // write sequencing
      case (state.wr_state)
         EPSR_WR_COLLECT: begin
            if (commit) begin
               next_state.wr_state = EPSR_WR_RESP;
               next_state.aw_got = 1'b0;
               next_state.w_got = 1'b0;
               // an address outside the map changes nothing and says so
               next_state.bresp = wr_hit ? EPSR_RESP_OKAY : EPSR_RESP_SLVERR;
            end
         end
         EPSR_WR_RESP: begin
            if (s_axi_bready) begin
               next_state.wr_state = EPSR_WR_COLLECT;
               next_state.bresp = EPSR_RESP_OKAY;
            end
         end
         default: begin
            next_state.wr_state = EPSR_WR_COLLECT;
         end
      endcase

      // read sequencing; data is sampled at the address edge so it is a
      // coherent snapshot of all fields
      case (state.rd_state)
         EPSR_RD_IDLE: begin
            if (ar_hs) begin
               next_state.rd_state = EPSR_RD_DATA;
               if (s_axi_araddr[EPSR_ADDR_W-1:2] == EPSR_ICS_OFFSET[EPSR_ADDR_W-1:2]) begin
                  next_state.rdata = ics_read;
                  next_state.rresp = EPSR_RESP_OKAY;
               end else begin
                  next_state.rdata = '0;
                  next_state.rresp = EPSR_RESP_SLVERR;
               end
            end
         end
         EPSR_RD_DATA: begin
            if (s_axi_rready) begin
               next_state.rd_state = EPSR_RD_IDLE;
               next_state.rdata = '0;
               next_state.rresp = EPSR_RESP_OKAY;
            end
         end
         default: begin
            next_state.rd_state = EPSR_RD_IDLE;
         end
      endcase
   end

   // register the bus state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule : epsr_ctrl

/* File: test/epsr_ctrl_properties.sv */
// concurrent checks on the ports of the pending-state register block
`timescale 1ns/100ps
module epsr_props
   import epsr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus signals watched
   input wire logic [EPSR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic [EPSR_DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   // core side
   input wire epsr_core_in_t core_in,
   input wire epsr_pend_out_t pend_out
);
   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // read answer to the mapped word; its snapshot was taken one edge before
   sequence rd_map;
      $rose(s_axi_rvalid) && $past(s_axi_araddr[7:2]) == 6'h01;
   endsequence

   a_svc_sw_only: assert property ($rose(pend_out.service_call_pending) |-> $rose(s_axi_bvalid))
      else $error("service call pending rose without a write");
   a_svc_read: assert property (rd_map |-> s_axi_rdata[28] == $past(pend_out.service_call_pending))
      else $error("service call bit wrong on read");
   a_svc_clear: assert property ($fell(pend_out.service_call_pending) |->
      $rose(s_axi_bvalid) || $past(core_in.service_call_taken))
      else $error("service call pending fell without cause");
   a_tick_set: assert property ($rose(pend_out.tick_pending) |->
      $rose(s_axi_bvalid) || $past(core_in.tick_event))
      else $error("tick pending rose without cause");
   a_tick_read: assert property (rd_map |-> s_axi_rdata[26] == $past(pend_out.tick_pending))
      else $error("tick bit wrong on read");
   a_tick_clear: assert property ($fell(pend_out.tick_pending) |->
      $rose(s_axi_bvalid) || $past(core_in.tick_taken))
      else $error("tick pending fell without cause");
   a_any_pend: assert property (rd_map |-> s_axi_rdata[22] == $past(core_in.external_irq_pending
      | pend_out.service_call_pending | pend_out.tick_pending))
      else $error("any pending bit wrong");
   // the any bit is checked above, so the field may lean on it
   a_pend_num: assert property (rd_map |-> s_axi_rdata[17:12] == (s_axi_rdata[22] ?
      $past(core_in.highest_pending_number) : 6'h00))
      else $error("pending number field wrong");
   a_act_num: assert property (rd_map |-> s_axi_rdata[5:0] == $past(core_in.interrupt_program_status)
      && s_axi_rresp == EPSR_RESP_OKAY)
      else $error("active number field wrong");
   a_rsvd_zero: assert property ($rose(s_axi_rvalid) |-> (s_axi_rdata & 32'hEBBC_0FC0) == 32'h0000_0000)
      else $error("reserved bits not zero");
   a_unmapped_rd: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[7:2]) != 6'h01 |->
      s_axi_rdata == 32'h0000_0000 && s_axi_rresp == EPSR_RESP_SLVERR)
      else $error("unmapped read answer wrong");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");

   // main scenarios reached
   c_rd_map: cover property (rd_map);
   c_svc_set: cover property ($rose(pend_out.service_call_pending));
   c_tick_hw: cover property ($fell(pend_out.tick_pending) && $past(core_in.tick_taken));
endmodule : epsr_props

bind epsr_ctrl epsr_props prop_u (.aclk, .aresetn, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .core_in, .pend_out);

/* File: test/tb_top.sv */
// self-checking bench for the pending-state register block
`timescale 1ns/100ps
module tb_top
   import epsr_pkg::*;
;
   logic aclk = 0, aresetn = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r0;
   logic [31:0] q0, d0;
   epsr_core_in_t core_in = '0;
   epsr_pend_out_t pend_out;
   logic svc_m = 0, tick_m = 0;
   int fails = 0, num_checks = 0;

   epsr_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_in(core_in), .pend_out(pend_out));

   // 40 MHz clock
   initial forever #12.5 aclk = ~aclk;

   // ***************************************************************
   // helpers
   // ***************************************************************
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
   endtask : check

   task end_sim;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // expected read image from the model flags and the core inputs
   function logic [31:0] img();
      logic any;
      any = core_in.external_irq_pending | svc_m | tick_m;
      return {3'h0, svc_m, 1'h0, tick_m, 3'h0, any, 4'h0, any ? core_in.highest_pending_number : 6'h00,
         6'h00, core_in.interrupt_program_status};
   endfunction : img

   // handshakes are sampled mid-cycle so the edge's own updates never race the decision;
   // bready is sometimes raised only once the response shows, so the response must wait
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int n;
      logic aw_ok, w_ok, got, b_seen;
      n = 0;
      got = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1'($urandom);
      while (!got && n < 50) begin
         @(negedge aclk);
         n++;
         aw_ok = awvalid & awready;
         w_ok = wvalid & wready;
         b_seen = (bvalid === 1'b1);
         if (b_seen && bready === 1'b1) begin
            got = 1;
            r = bresp;
         end
         @(posedge aclk);
         if (aw_ok) awvalid <= 0;
         if (w_ok) wvalid <= 0;
         bready <= !got && (bready || b_seen);
      end
      check("write answer", 32'(got), 32'h0000_0001);
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic took, got;
      n = 0;
      took = 0;
      got = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      while (!got && n < 50) begin
         @(negedge aclk);
         n++;
         if (arvalid & arready) took = 1;
         if (rvalid === 1'b1) begin
            got = 1;
            d = rdata;
            r = rresp;
         end
         @(posedge aclk);
         if (took) arvalid <= 0;
         if (got) rready <= 0;
      end
      check("read answer", 32'(got), 32'h0000_0001);
   endtask : rd

   task look;
      logic [31:0] q;
      logic [1:0] r;
      rd(EPSR_ICS_OFFSET, q, r);
      check("rresp", 32'(r), 32'(EPSR_RESP_OKAY));
      check("image", q, img());
      check("irq index", 32'(q[5:0]) - 32'd16, 32'(core_in.interrupt_program_status) - 32'd16);
      check("pend_out", 32'(pend_out), 32'({svc_m, tick_m}));
   endtask : look

   // write, update the model (clear beats set), then read back
   task wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      logic m;
      m = (a[7:2] == 6'h01);
      wr(a, d, s, r);
      if (m && s[3]) begin
         svc_m = !d[27] && (d[28] || svc_m);
         tick_m = !d[25] && (d[26] || tick_m);
      end
      check("bresp", 32'(r), 32'(m ? EPSR_RESP_OKAY : EPSR_RESP_SLVERR));
      look;
   endtask : wrc

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      void'($urandom(32'h9df1_c60c));
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      look;
      wrc(EPSR_ICS_OFFSET, 32'h1000_0000, 4'hF);
      wrc(EPSR_ICS_OFFSET, 32'h0000_0000, 4'hF);
      wrc(EPSR_ICS_OFFSET, 32'h0800_0000, 4'hF);
      wrc(EPSR_ICS_OFFSET, 32'h0400_0000, 4'hF);
      wrc(EPSR_ICS_OFFSET, 32'h0200_0000, 4'hF);
      wrc(EPSR_ICS_OFFSET, 32'h1400_0000, 4'hF);
      wrc(EPSR_ICS_OFFSET, 32'h1E00_0000, 4'hF);
      wrc(EPSR_ICS_OFFSET, 32'h1400_0000, 4'h7);
      wrc(8'h08, 32'h1400_0000, 4'hF);
      wrc(EPSR_ICS_OFFSET, 32'hFFFF_FFFF, 4'hF);
      rd(8'h00, q0, r0);
      check("unmapped rdata", q0, 32'h0000_0000);
      check("unmapped rresp", 32'(r0), 32'(EPSR_RESP_SLVERR));
      // hardware events: a tick event must never raise the service call
      @(posedge aclk) core_in.tick_event <= 1'b1;
      @(posedge aclk) core_in.tick_event <= 1'b0;
      tick_m = 1;
      look;
      @(posedge aclk) core_in.tick_taken <= 1'b1;
      @(posedge aclk) core_in.tick_taken <= 1'b0;
      tick_m = 0;
      wrc(EPSR_ICS_OFFSET, 32'h1000_0000, 4'hF);
      @(posedge aclk) core_in.service_call_taken <= 1'b1;
      @(posedge aclk) core_in.service_call_taken <= 1'b0;
      svc_m = 0;
      look;
      // reset in mid-run drops both flags; held three edges so no false fall is seen
      wrc(EPSR_ICS_OFFSET, 32'h1400_0000, 4'hF);
      @(posedge aclk) aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      svc_m = 0;
      tick_m = 0;
      @(negedge aclk);
      check("after reset", 32'({awready, wready, arready, bvalid, rvalid, pend_out}), 32'h0000_0070);
      look;
      // random traffic and core status
      repeat (40) begin
         @(posedge aclk);
         core_in.highest_pending_number <= 6'($urandom);
         core_in.external_irq_pending <= 1'($urandom);
         core_in.interrupt_program_status <= 6'($urandom);
         // software never sets and clears one exception together
         d0 = $urandom;
         d0[28] = d0[28] & !d0[27];
         d0[26] = d0[26] & !d0[25];
         wrc(EPSR_ICS_OFFSET, d0, 4'($urandom));
      end
      end_sim;
   end

   // watchdog, several times the expected run length
   initial begin
      #125000;
      fails++;
      end_sim;
   end
endmodule : tb_top
